// File: design/usc_status_clear_data.sv
// Behaviour
// - Auto-baud error bit 14 set on detection failure, cleared by auto-baud request
// - Auto-baud bit 15 set on enable or interruption, cleared on resumed detection
// - Busy bit 16 follows reception from start bit to end, hardware only
// - Match bit 17 set on received char equal 8-bit value, clear bit 17
// - Break bit 18 set by break request, cleared at break stop bit
// - Mute bit 19 mirrors mute state; mute request sets it with idle wake
// - Wake bit 20 set on wake detect, interrupts while set if its mask bit and enable are set, clear bit 20
// - Transmit ack bit 21 set on sampled enable; enable drop requests idle frame
// - Receive ack bit 22 set once receiver sampled its enable
// - Clear bits 0..4 at 0x20 clear parity, framing, noise, overrun, idle
// - Clear bits 6,8,9,11,12 clear tx-done, break, cts, timeout, end-of-block
// - Receive word at 0x24 gives 9-bit character, top bit parity when enabled
// - Transmit word at 0x28 holds 9 bits; top bit replaced by parity when enabled
// - Auto-baud request clears auto-baud flag and arms fresh measurement
// - Wake interrupt only when its enable is set and wake flag sets
// - Mute request puts the receiver into mute mode when idle wake is selected; here it only sets mute bit 19, no output reaches the receiver
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "usc_defs.svh"

module usc_status_clear_data (
	// Clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  arst_n,
	// Avalon-MM slave
	input  wire logic [5:0]            address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire usc_pkg::usc_word_type writedata,
	output usc_pkg::usc_word_type      readdata,
	output logic                       waitrequest,
	// Receiver events
	input  wire logic                  ev_parity_err,
	input  wire logic                  ev_framing_err,
	input  wire logic                  ev_noise_err,
	input  wire logic                  ev_overrun,
	input  wire logic                  ev_idle_line,
	input  wire logic                  ev_line_break,
	input  wire logic                  ev_cts_change,
	input  wire logic                  ev_rx_timeout,
	input  wire logic                  ev_end_of_block,
	input  wire logic                  ev_rx_start,
	input  wire logic                  ev_rx_done,
	input  wire usc_pkg::usc_char_type rx_char,
	input  wire logic                  ev_wake_detect,
	input  wire logic                  ev_mute_enter,
	input  wire logic                  ev_mute_exit,
	input  wire logic                  ev_autobaud_fail,
	input  wire logic                  ev_autobaud_abort,
	input  wire logic                  ev_autobaud_resume,
	// Transmitter events
	input  wire logic                  ev_tx_done,
	input  wire logic                  ev_break_stop,
	input  wire logic                  tx_enable_sampled,
	input  wire logic                  rx_enable_sampled,
	// Controls to the shifters
	output logic                       transmitter_enable,
	output logic                       receiver_enable,
	output logic                       autobaud_arm,
	output logic                       break_send_pulse,
	output logic                       idle_frame_request,
	output usc_pkg::usc_char_type      outgoing_word,
	// Interrupt
	output logic                       irq
);
	import usc_pkg::*;

	usc_word_type status_flags;
	usc_word_type control;
	usc_word_type int_mask;
	usc_char_type received_word;
	usc_char_type tx_store;
	usc_bus_type  bus_state;
	usc_word_type next_readdata;
	logic         wr_hit;
	logic         ab_en_q;
	logic         parity_on;
	logic [7:0]   match_value;
	logic         req_wr;
	usc_word_type clr_bits;
	usc_word_type set_bits;
	usc_word_type wake_sel;

	// Writes commit at the edge that samples waitrequest low, never earlier
	assign wr_hit      = write && (bus_state == USC_BUS_ANSWER);
	assign req_wr      = wr_hit && address == `USC_OFF_REQUEST;
	assign wake_sel    = 32'h1 << `USC_B_WAKE;
	assign parity_on   = control[`USC_C_PARITY];
	assign match_value = control[`USC_C_MATCH_LSB +: 8];

	// One wait cycle per access, answer on the second edge
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			bus_state   <= USC_BUS_IDLE;
			waitrequest <= 1'b1;
		end else begin
			case (bus_state)
				USC_BUS_IDLE: begin
					if (read || write) begin
						bus_state   <= USC_BUS_ANSWER;
						waitrequest <= 1'b0;
					end
				end
				USC_BUS_ANSWER: begin
					bus_state   <= USC_BUS_IDLE;
					waitrequest <= 1'b1;
				end
				default: begin
					bus_state   <= USC_BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Read multiplexer, unmapped reads return zero
	always_comb begin
		next_readdata = 32'h0000_0000;
		case (address)
			`USC_OFF_STATUS:  next_readdata = status_flags;
			`USC_OFF_RXWORD:  next_readdata = {23'h000000, received_word};
			`USC_OFF_TXWORD:  next_readdata = {23'h000000, tx_store};
			`USC_OFF_CONTROL: next_readdata = control;
			`USC_OFF_MASK:    next_readdata = int_mask;
			default:          next_readdata = 32'h0000_0000;
		endcase
	end

	// Read data registered with the answer
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			readdata <= 32'h0000_0000;
		end else if (read && bus_state == USC_BUS_IDLE) begin
			readdata <= next_readdata;
		end
	end

	// Control and mask registers; the status register is not writable
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			control  <= `USC_CONTROL_RST;
			int_mask <= `USC_MASK_RST;
		end else if (wr_hit) begin
			if (address == `USC_OFF_CONTROL) begin
				control <= writedata;
			end
			if (address == `USC_OFF_MASK) begin
				int_mask <= writedata;
			end
		end
	end

	// Enables to the shifters and idle frame on transmitter disable
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			transmitter_enable <= 1'b0;
			receiver_enable    <= 1'b0;
			idle_frame_request <= 1'b0;
			ab_en_q            <= 1'b0;
		end else begin
			transmitter_enable <= control[`USC_C_TRANSMITTER_ENABLE];
			receiver_enable    <= control[`USC_C_RECEIVER_ENABLE];
			idle_frame_request <= transmitter_enable && !control[`USC_C_TRANSMITTER_ENABLE];
			ab_en_q            <= control[`USC_C_ABEN];
		end
	end

	// Request strobes towards the shifters
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			autobaud_arm     <= 1'b0;
			break_send_pulse <= 1'b0;
		end else begin
			autobaud_arm     <= wr_hit && address == `USC_OFF_REQUEST
				&& writedata[`USC_Q_AUTOBAUD];
			break_send_pulse <= wr_hit && address == `USC_OFF_REQUEST
				&& writedata[`USC_Q_BREAK];
		end
	end

	// Transmit word; parity position replaced when parity is on
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			tx_store      <= 9'h000;
			outgoing_word <= 9'h000;
		end else begin
			if (wr_hit && address == `USC_OFF_TXWORD) begin
				tx_store <= writedata[8:0];
			end
			outgoing_word <= parity_on ? {^tx_store[7:0], tx_store[7:0]} : tx_store;
		end
	end

	// Receive word captured at end of character
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			received_word <= 9'h000;
		end else if (ev_rx_done) begin
			received_word <= rx_char;
		end
	end

	// Set and clear vectors of the sticky flags
	always_comb begin
		clr_bits = 32'h0000_0000;
		set_bits = 32'h0000_0000;
		if (wr_hit && address == `USC_OFF_CLEAR) begin
			clr_bits = writedata & `USC_CLEAR_MASK;
		end
		set_bits[`USC_B_PARITY]  = ev_parity_err;
		set_bits[`USC_B_FRAMING] = ev_framing_err;
		set_bits[`USC_B_NOISE]   = ev_noise_err;
		set_bits[`USC_B_OVERRUN] = ev_overrun;
		set_bits[`USC_B_IDLE]    = ev_idle_line;
		set_bits[`USC_B_TXDONE]  = ev_tx_done;
		set_bits[`USC_B_LBREAK]  = ev_line_break;
		set_bits[`USC_B_CTS]     = ev_cts_change;
		set_bits[`USC_B_RXTO]    = ev_rx_timeout;
		set_bits[`USC_B_EOB]     = ev_end_of_block;
		set_bits[`USC_B_MATCH]   = ev_rx_done && rx_char[7:0] == match_value;
		set_bits[`USC_B_WAKE]    = ev_wake_detect;
	end

	// Sticky status flags: set wins over clear, bus writes to the status offset never reach this word
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			status_flags <= `USC_STATUS_RST;
		end else begin
			status_flags <= (status_flags & ~clr_bits) | set_bits;
			// Auto-baud error: request clears, failure sets
			if (ev_autobaud_fail) begin
				status_flags[`USC_B_ABERR] <= 1'b1;
			end else if (req_wr && writedata[`USC_Q_AUTOBAUD]) begin
				status_flags[`USC_B_ABERR] <= 1'b0;
			end
			// Auto-baud flag
			if ((control[`USC_C_ABEN] && !ab_en_q) || ev_autobaud_abort) begin
				status_flags[`USC_B_ABFLG] <= 1'b1;
			end else if (ev_autobaud_resume || (req_wr && writedata[`USC_Q_AUTOBAUD])) begin
				status_flags[`USC_B_ABFLG] <= 1'b0;
			end
			// Busy follows reception
			if (ev_rx_start) begin
				status_flags[`USC_B_BUSY] <= 1'b1;
			end else if (ev_rx_done) begin
				status_flags[`USC_B_BUSY] <= 1'b0;
			end
			// Break pending
			if (req_wr && writedata[`USC_Q_BREAK]) begin
				status_flags[`USC_B_BREAK] <= 1'b1;
			end else if (ev_break_stop) begin
				status_flags[`USC_B_BREAK] <= 1'b0;
			end
			// Mute state
			if (ev_mute_enter || (req_wr && writedata[`USC_Q_MUTE]
				&& control[`USC_C_IDLEWAKE])) begin
				status_flags[`USC_B_MUTE] <= 1'b1;
			end else if (ev_mute_exit) begin
				status_flags[`USC_B_MUTE] <= 1'b0;
			end
			// Enable acknowledges follow the sampled enables
			status_flags[`USC_B_TXACK] <= tx_enable_sampled;
			status_flags[`USC_B_RXACK] <= rx_enable_sampled;
		end
	end

	// Level interrupt: masked status; the wake bit also needs its own enable
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_flags & int_mask & ~wake_sel)
				|| (status_flags[`USC_B_WAKE] && int_mask[`USC_B_WAKE]
				&& control[`USC_C_WAKEIE]);
		end
	end

	// Checks
	a_match_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_rx_done && rx_char[7:0] == match_value |=> status_flags[`USC_B_MATCH])
		else $error("match flag not set");
	a_busy_start: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_rx_start |=> status_flags[`USC_B_BUSY])
		else $error("busy not set on start");
	a_busy_done: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_rx_done && !ev_rx_start |=> !status_flags[`USC_B_BUSY])
		else $error("busy not cleared");
	a_clear_parity: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_CLEAR && writedata[0] && !ev_parity_err
		|=> !status_flags[`USC_B_PARITY])
		else $error("parity flag not cleared");
	a_clear_eob: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_CLEAR && writedata[12] && !ev_end_of_block
		|=> !status_flags[`USC_B_EOB])
		else $error("end-of-block flag not cleared");
	a_break_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_REQUEST && writedata[1]
		|=> status_flags[`USC_B_BREAK] && break_send_pulse)
		else $error("break request not taken");
	a_status_ro: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_STATUS && !ev_parity_err && !ev_framing_err
		|=> status_flags[1:0] == $past(status_flags[1:0]))
		else $error("status write changed a flag");
	a_wake_irq: assert property (@(posedge clk_sys) disable iff (!arst_n)
		(ev_wake_detect && control[`USC_C_WAKEIE] && int_mask[`USC_B_WAKE])
		##1 (control[`USC_C_WAKEIE] && int_mask[`USC_B_WAKE]) |=> irq)
		else $error("wake interrupt missing");
	a_abaud_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_REQUEST && writedata[0] && !ev_autobaud_fail
		|=> !status_flags[`USC_B_ABERR] && autobaud_arm)
		else $error("auto-baud request not handled");
	a_parity_tx: assert property (@(posedge clk_sys) disable iff (!arst_n)
		parity_on |=> outgoing_word[8] == ^$past(tx_store[7:0]))
		else $error("parity bit not generated");

	// Hardware-driven flags and the idle frame request
	a_wake_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_wake_detect |=> status_flags[`USC_B_WAKE])
		else $error("wake flag not set");
	a_aberr_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_autobaud_fail |=> status_flags[`USC_B_ABERR])
		else $error("auto-baud error flag not set");
	a_abflg_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_autobaud_abort |=> status_flags[`USC_B_ABFLG])
		else $error("auto-baud flag not set on abort");
	a_abflg_resume: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_autobaud_resume && !ev_autobaud_abort && !(control[`USC_C_ABEN] && !ab_en_q)
		|=> !status_flags[`USC_B_ABFLG])
		else $error("auto-baud flag not cleared on resume");
	a_break_stop: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_break_stop && !(req_wr && writedata[`USC_Q_BREAK])
		|=> !status_flags[`USC_B_BREAK])
		else $error("break flag not cleared at stop bit");
	a_mute_exit: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_mute_exit && !ev_mute_enter && !(req_wr && writedata[`USC_Q_MUTE])
		|=> !status_flags[`USC_B_MUTE])
		else $error("mute flag not cleared on wake");
	a_tx_ack: assert property (@(posedge clk_sys) disable iff (!arst_n)
		1'b1 |=> status_flags[`USC_B_TXACK] == $past(tx_enable_sampled))
		else $error("transmit acknowledge not following");
	a_rx_ack: assert property (@(posedge clk_sys) disable iff (!arst_n)
		1'b1 |=> status_flags[`USC_B_RXACK] == $past(rx_enable_sampled))
		else $error("receive acknowledge not following");
	a_idle_frame: assert property (@(posedge clk_sys) disable iff (!arst_n)
		transmitter_enable && !control[`USC_C_TRANSMITTER_ENABLE] |=> idle_frame_request)
		else $error("idle frame not requested");

	// Bus-side clears and requests
	a_clear_overrun: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_CLEAR && writedata[`USC_B_OVERRUN] && !ev_overrun
		|=> !status_flags[`USC_B_OVERRUN])
		else $error("overrun flag not cleared");
	a_clear_txdone: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_CLEAR && writedata[`USC_B_TXDONE] && !ev_tx_done
		|=> !status_flags[`USC_B_TXDONE])
		else $error("transmit complete flag not cleared");
	a_match_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_CLEAR && writedata[`USC_B_MATCH]
		&& !(ev_rx_done && rx_char[7:0] == match_value) |=> !status_flags[`USC_B_MATCH])
		else $error("match flag not cleared");
	a_wake_clear: assert property (@(posedge clk_sys) disable iff (!arst_n)
		wr_hit && address == `USC_OFF_CLEAR && writedata[`USC_B_WAKE] && !ev_wake_detect
		|=> !status_flags[`USC_B_WAKE])
		else $error("wake flag not cleared");
	a_mute_req: assert property (@(posedge clk_sys) disable iff (!arst_n)
		req_wr && writedata[`USC_Q_MUTE] && control[`USC_C_IDLEWAKE]
		|=> status_flags[`USC_B_MUTE])
		else $error("mute request not taken");

	// Data path and interrupt
	a_rx_word: assert property (@(posedge clk_sys) disable iff (!arst_n)
		ev_rx_done |=> received_word == $past(rx_char))
		else $error("received word not captured");
	a_tx_keep: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!parity_on |=> outgoing_word == $past(tx_store))
		else $error("transmit word altered without parity");
	a_wake_quiet: assert property (@(posedge clk_sys) disable iff (!arst_n)
		!control[`USC_C_WAKEIE] && (status_flags & int_mask & ~wake_sel) == 32'h0000_0000
		|=> !irq)
		else $error("interrupt without enabled source");

endmodule

// File: design/usc_defs.svh
`ifndef USC_DEFS_SVH
`define USC_DEFS_SVH

// Register byte offsets
`define USC_OFF_REQUEST   6'h18
`define USC_OFF_STATUS    6'h1C
`define USC_OFF_CLEAR     6'h20
`define USC_OFF_RXWORD    6'h24
`define USC_OFF_TXWORD    6'h28
`define USC_OFF_CONTROL   6'h2C
`define USC_OFF_MASK      6'h30

// Status flag positions
`define USC_B_PARITY      0
`define USC_B_FRAMING     1
`define USC_B_NOISE       2
`define USC_B_OVERRUN     3
`define USC_B_IDLE        4
`define USC_B_TXDONE      6
`define USC_B_LBREAK      8
`define USC_B_CTS         9
`define USC_B_RXTO        11
`define USC_B_EOB         12
`define USC_B_ABERR       14
`define USC_B_ABFLG       15
`define USC_B_BUSY        16
`define USC_B_MATCH       17
`define USC_B_BREAK       18
`define USC_B_MUTE        19
`define USC_B_WAKE        20
`define USC_B_TXACK       21
`define USC_B_RXACK       22

// Request register bits
`define USC_Q_AUTOBAUD    0
`define USC_Q_BREAK       1
`define USC_Q_MUTE        2

// Control register bits
`define USC_C_TRANSMITTER_ENABLE        0
`define USC_C_RECEIVER_ENABLE        1
`define USC_C_PARITY      2
`define USC_C_WAKEIE      3
`define USC_C_IDLEWAKE    4
`define USC_C_ABEN        5
`define USC_C_MATCH_LSB   8

// Writable-to-clear bit set and reset values
`define USC_CLEAR_MASK    32'h0012_1B5F
`define USC_STATUS_RST    32'h0000_0000
`define USC_CONTROL_RST   32'h0000_0000
`define USC_MASK_RST      32'h0000_0000

`endif

// File: design/usc_pkg.sv
package usc_pkg;
	typedef logic [31:0] usc_word_type;
	typedef logic [8:0]  usc_char_type;
	typedef enum logic [1:0] {
		USC_BUS_IDLE,
		USC_BUS_ANSWER
	} usc_bus_type;
endpackage

// File: tb/usc_status_clear_data_tb_top.sv
`timescale 1ns/1ps
`include "usc_defs.svh"

module usc_status_clear_data_tb_top;
	import usc_pkg::*;

	// Bus, events and observed outputs
	logic         clk_sys, arst_n, read, write, waitrequest, irq, tx_s, rx_s;
	logic         tx_en, rx_en, arm, brk, idle_req;
	logic [5:0]   address;
	logic [18:0]  ev;
	usc_word_type writedata, readdata, rd, ctrl, m;
	usc_char_type rx_char, out_word;
	int           errors, n_tests, seed, n_arm, n_brk, n_idle;
	int           cb[11] = '{0, 1, 2, 3, 4, 6, 8, 9, 11, 12, 20};
	int           ce[11] = '{0, 1, 2, 3, 4, 9, 5, 6, 7, 8, 10};

	usc_status_clear_data i_dut (
		.clk_sys(clk_sys), .arst_n(arst_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.ev_parity_err(ev[0]), .ev_framing_err(ev[1]), .ev_noise_err(ev[2]),
		.ev_overrun(ev[3]), .ev_idle_line(ev[4]), .ev_line_break(ev[5]),
		.ev_cts_change(ev[6]), .ev_rx_timeout(ev[7]), .ev_end_of_block(ev[8]),
		.ev_tx_done(ev[9]), .ev_wake_detect(ev[10]), .ev_rx_start(ev[11]),
		.ev_rx_done(ev[12]), .ev_mute_enter(ev[13]), .ev_mute_exit(ev[14]),
		.ev_autobaud_fail(ev[15]), .ev_autobaud_abort(ev[16]),
		.ev_autobaud_resume(ev[17]), .ev_break_stop(ev[18]), .rx_char(rx_char),
		.tx_enable_sampled(tx_s), .rx_enable_sampled(rx_s), .transmitter_enable(tx_en),
		.receiver_enable(rx_en), .autobaud_arm(arm), .break_send_pulse(brk),
		.idle_frame_request(idle_req), .outgoing_word(out_word), .irq(irq)
	);

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Count the one-cycle control pulses
	always @(posedge clk_sys) begin
		if (arm === 1'b1) n_arm++;
		if (brk === 1'b1) n_brk++;
		if (idle_req === 1'b1) n_idle++;
	end

	task automatic chk(input usc_word_type got, input usc_word_type exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: word %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("Error %0t: flag %b expected %b", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a, input usc_word_type d);
		int n;
		n = 0;
		@(posedge clk_sys);
		address   <= a;
		write     <= w;
		read      <= !w;
		writedata <= d;
		do begin
			@(posedge clk_sys);
			n++;
		end while (waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			errors++;
			$display("Error %0t: no bus answer", $time);
		end
		rd = readdata;
		read  <= 1'b0;
		write <= 1'b0;
	endtask

	task automatic pulse(input int i);
		@(posedge clk_sys);
		ev <= 19'(1) << i;
		@(posedge clk_sys);
		ev <= '0;
	endtask

	task automatic sbit(input int b, input logic e);
		bus(1'b0, `USC_OFF_STATUS, 32'h0);
		chk_bit(rd[b], e);
	endtask

	function automatic usc_char_type exp_tx(input usc_word_type d, input logic p);
		return p ? {^d[7:0], d[7:0]} : d[8:0];
	endfunction

	task summarize;
		$display("checks %0d errors %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog, well past the few hundred cycles the tests need
	initial begin
		#40000;
		errors++;
		$display("Error %0t: timeout", $time);
		summarize;
	end

	initial begin
		seed = 26;
		{read, write, address, writedata, ev, rx_char, tx_s, rx_s} = '0;
		arst_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		bus(1'b0, `USC_OFF_STATUS, 32'h0);
		chk(rd, `USC_STATUS_RST);
		bus(1'b0, `USC_OFF_CLEAR, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, 6'h3C, 32'h0);
		chk(rd, 32'h0);
		$display("reset test done");
		// Event sets flag; status write and partial clear leave it; its own bit clears it
		for (int i = 0; i < 11; i++) begin
			pulse(ce[i]);
			bus(1'b1, `USC_OFF_STATUS, 32'h0);
			m = $random(seed);
			bus(1'b1, `USC_OFF_CLEAR, m & ~(32'h1 << cb[i]));
			sbit(cb[i], 1'b1);
			bus(1'b1, `USC_OFF_CLEAR, 32'h1 << cb[i]);
			sbit(cb[i], 1'b0);
		end
		$display("clear test done");
		// Wake interrupt needs mask and enable
		bus(1'b1, `USC_OFF_MASK, 32'h1 << 20);
		pulse(10);
		sbit(20, 1'b1);
		chk_bit(irq, 1'b0);
		bus(1'b1, `USC_OFF_CLEAR, 32'h1 << 20);
		bus(1'b1, `USC_OFF_CONTROL, 32'h8);
		pulse(10);
		sbit(20, 1'b1);
		chk_bit(irq, 1'b1);
		bus(1'b1, `USC_OFF_CLEAR, 32'h1 << 20);
		sbit(20, 1'b0);
		chk_bit(irq, 1'b0);
		pulse(0);
		sbit(0, 1'b1);
		chk_bit(irq, 1'b0);
		bus(1'b1, `USC_OFF_MASK, 32'h1);
		sbit(0, 1'b1);
		chk_bit(irq, 1'b1);
		bus(1'b1, `USC_OFF_CLEAR, 32'h1);
		sbit(0, 1'b0);
		chk_bit(irq, 1'b0);
		$display("interrupt test done");
		// Receive: busy span, match and received word with parity bit on top
		m = $random(seed);
		ctrl = 32'h6 | (32'(m[7:0]) << 8);
		bus(1'b1, `USC_OFF_CONTROL, ctrl);
		pulse(11);
		sbit(16, 1'b1);
		chk_bit(rx_en, 1'b1);
		rx_char <= {1'b1, m[7:0]};
		pulse(12);
		sbit(16, 1'b0);
		chk_bit(rd[17], 1'b1);
		bus(1'b0, `USC_OFF_RXWORD, 32'h0);
		chk(rd, {23'h0, 1'b1, m[7:0]});
		bus(1'b1, `USC_OFF_CLEAR, 32'h1 << 17);
		rx_char <= {1'b0, m[7:0] ^ 8'h01};
		pulse(12);
		sbit(17, 1'b0);
		$display("receive test done");
		// Transmit word with and without generated parity
		for (int k = 0; k < 6; k++) begin
			m = (k == 0) ? 32'h1FF : $random(seed);
			ctrl = k[0] ? 32'h0 : 32'h4;
			bus(1'b1, `USC_OFF_CONTROL, ctrl);
			bus(1'b1, `USC_OFF_TXWORD, m);
			bus(1'b0, `USC_OFF_STATUS, 32'h0);
			chk(32'(out_word), 32'(exp_tx(m, ctrl[2])));
		end
		$display("transmit test done");
		// Auto-baud flags and request
		bus(1'b1, `USC_OFF_CONTROL, 32'h20);
		sbit(15, 1'b1);
		pulse(15);
		sbit(14, 1'b1);
		bus(1'b1, `USC_OFF_REQUEST, 32'h1);
		sbit(14, 1'b0);
		chk_bit(rd[15], 1'b0);
		chk(n_arm, 1);
		pulse(16);
		sbit(15, 1'b1);
		pulse(17);
		sbit(15, 1'b0);
		// Break request held until the break stop bit
		bus(1'b1, `USC_OFF_REQUEST, 32'h2);
		sbit(18, 1'b1);
		chk(n_brk, 1);
		pulse(18);
		sbit(18, 1'b0);
		// Mute state
		bus(1'b1, `USC_OFF_CONTROL, 32'h10);
		bus(1'b1, `USC_OFF_REQUEST, 32'h4);
		sbit(19, 1'b1);
		pulse(14);
		sbit(19, 1'b0);
		pulse(13);
		sbit(19, 1'b1);
		$display("request test done");
		// Enable acknowledges and idle frame on transmitter disable
		tx_s <= 1'b1;
		rx_s <= 1'b1;
		bus(1'b1, `USC_OFF_CONTROL, 32'h3);
		sbit(21, 1'b1);
		chk_bit(rd[22], 1'b1);
		chk_bit(tx_en, 1'b1);
		bus(1'b1, `USC_OFF_CONTROL, 32'h2);
		bus(1'b0, `USC_OFF_STATUS, 32'h0);
		chk_bit(tx_en, 1'b0);
		chk(n_idle, 1);
		$display("enable test done");
		summarize;
	end
endmodule
